// File: program_counter_and_return_stack.sv
// Overview of operation
// - program counter is thirteen bits wide
// - low pc byte readable and writable
// - upper pc bits not written directly by bus
// - every reset clears whole program counter
// - low byte write loads upper from latch
// - branch: eleven instruction bits, page from latch
// - eight entry thirteen bit private stack
// - stack pointer has no software path
// - call or interrupt vector pushes pc
// - return op pops stack
// - return restores all thirteen pc bits
// - push and pop leave latch alone
// - stack wraps, ninth push overwrites first
// - no overflow or underflow indication
// - stack moves only on branch events
// - addresses a continuous 8K word space
module program_counter_and_return_stack #(
  parameter logic [12:0] VECTOR_ADDR = 13'h0004
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        advance_i,
  input  wire logic        direct_jump_op_i,
  input  wire logic        subroutine_op_i,
  input  wire logic [10:0] branch_addr_i,
  input  wire logic        return_op_i,
  input  wire logic        interrupt_vector_i,
  output logic      [12:0] pc_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [pc_stack_pkg::PC_WIDTH-1:0]                                  pc;
    logic [pc_stack_pkg::LATCH_WIDTH-1:0]                               latch;
    logic [pc_stack_pkg::STACK_DEPTH-1:0][pc_stack_pkg::PC_WIDTH-1:0]   stack;
    logic [pc_stack_pkg::SP_WIDTH-1:0]                                  sp;
    logic                                                               ack;
    logic [pc_stack_pkg::LOW_WIDTH-1:0]                                 rdata;
  } state_type;

  state_type              s_q;
  state_type              s_d;
  logic                   bus_req;
  logic                   low_write;
  logic                   latch_write;
  pc_stack_pkg::event_type ev;
  logic                                 push_en;
  logic                                 pop_en;
  logic [pc_stack_pkg::SP_WIDTH-1:0]    pop_index;
  logic [pc_stack_pkg::PC_WIDTH-1:0]    branch_target;
  logic [pc_stack_pkg::LATCH_WIDTH-1:0] pc_upper_bits;

  assign bus_req     = cyc_i & stb_i & ~s_q.ack;
  assign low_write   = bus_req & we_i & sel_i[0] & (adr_i == pc_stack_pkg::OFFSET_PC_LOW);
  assign latch_write = bus_req & we_i & sel_i[0] & (adr_i == pc_stack_pkg::OFFSET_PC_LATCH);

  // ==========================================================================
  // stack movement, only as a side effect of core events
  assign push_en   = (ev == pc_stack_pkg::EV_VECTOR) || (ev == pc_stack_pkg::EV_CALL);
  assign pop_en    = (ev == pc_stack_pkg::EV_RETURN);
  assign pop_index = s_q.sp - pc_stack_pkg::SP_STEP;

  // ==========================================================================
  // branch target: page from latch, offset from instruction
  assign pc_upper_bits = s_q.latch;
  assign branch_target = {s_q.latch[pc_stack_pkg::PAGE_HI_BIT:pc_stack_pkg::PAGE_LO_BIT],
                          branch_addr_i};

  // ==========================================================================
  // event priority
  always_comb begin
    if (interrupt_vector_i) begin
      ev = pc_stack_pkg::EV_VECTOR;
    end else if (return_op_i) begin
      ev = pc_stack_pkg::EV_RETURN;
    end else if (subroutine_op_i) begin
      ev = pc_stack_pkg::EV_CALL;
    end else if (direct_jump_op_i) begin
      ev = pc_stack_pkg::EV_JUMP;
    end else if (low_write) begin
      ev = pc_stack_pkg::EV_LOW_WRITE;
    end else if (advance_i) begin
      ev = pc_stack_pkg::EV_ADVANCE;
    end else begin
      ev = pc_stack_pkg::EV_NONE;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    if (bus_req) begin
      s_d.ack   = 1'b1;
      s_d.rdata = '0;
      if (adr_i == pc_stack_pkg::OFFSET_PC_LOW) begin
        s_d.rdata = s_q.pc[pc_stack_pkg::LOW_WIDTH-1:0];
      end else if (adr_i == pc_stack_pkg::OFFSET_PC_LATCH) begin
        s_d.rdata[pc_stack_pkg::LATCH_WIDTH-1:0] = s_q.latch;
      end
    end
    if (latch_write) begin
      s_d.latch = dat_i[pc_stack_pkg::LATCH_WIDTH-1:0];
    end
    case (ev)
      pc_stack_pkg::EV_VECTOR: begin
        s_d.pc = VECTOR_ADDR;
      end
      pc_stack_pkg::EV_RETURN: begin
        s_d.pc = s_q.stack[pop_index];
      end
      pc_stack_pkg::EV_CALL: begin
        s_d.pc = branch_target;
      end
      pc_stack_pkg::EV_JUMP: begin
        s_d.pc = branch_target;
      end
      pc_stack_pkg::EV_LOW_WRITE: begin
        s_d.pc = {pc_upper_bits, dat_i[pc_stack_pkg::LOW_WIDTH-1:0]};
      end
      pc_stack_pkg::EV_ADVANCE: begin
        s_d.pc = s_q.pc + pc_stack_pkg::PC_STEP;
      end
      pc_stack_pkg::EV_NONE: begin
        s_d.pc = s_q.pc;
      end
      default: begin
        s_d.pc = s_q.pc;
      end
    endcase
    // pointer wraps silently in both directions, no flag
    if (push_en) begin
      s_d.stack[s_q.sp] = s_q.pc;
      s_d.sp            = s_q.sp + pc_stack_pkg::SP_STEP;
    end else if (pop_en) begin
      s_d.sp = pop_index;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.pc    <= pc_stack_pkg::PC_RESET;
      s_q.latch <= pc_stack_pkg::LATCH_RESET;
      s_q.stack <= '0;
      s_q.sp    <= pc_stack_pkg::SP_RESET;
      s_q.ack   <= 1'b0;
      s_q.rdata <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs, straight from the state register
  assign dat_o = {{(pc_stack_pkg::DATA_WIDTH-pc_stack_pkg::LOW_WIDTH){1'b0}}, s_q.rdata};
  assign ack_o = s_q.ack;
  assign pc_o  = s_q.pc;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_call_alone;
    subroutine_op_i && !interrupt_vector_i && !return_op_i;
  endsequence

  sequence s_return_alone;
    return_op_i && !interrupt_vector_i;
  endsequence

  sequence s_push_alone;
    (subroutine_op_i || interrupt_vector_i) && !(return_op_i && !interrupt_vector_i);
  endsequence

  a_reset_clears_pc: assert property ($past(rst_i) |->
    pc_o == pc_stack_pkg::PC_RESET && s_q.sp == pc_stack_pkg::SP_RESET)
    else $error("pc or stack pointer not cleared by reset");

  a_low_write_load: assert property (
    (ev == pc_stack_pkg::EV_LOW_WRITE) |=> pc_o == {$past(s_q.latch), $past(dat_i[7:0])})
    else $error("low byte write did not load pc from latch");

  a_branch_page_select: assert property (
    (ev == pc_stack_pkg::EV_JUMP || ev == pc_stack_pkg::EV_CALL) |=>
      pc_o[12:11] == $past(s_q.latch[4:3]) && pc_o[10:0] == $past(branch_addr_i))
    else $error("branch target not formed from latch page and instruction");

  a_call_return_pair: assert property (s_call_alone ##1 s_return_alone |=> pc_o == $past(pc_o, 2))
    else $error("return did not restore pc saved by the call");

  a_latch_kept: assert property (
    (return_op_i || subroutine_op_i || interrupt_vector_i) && !latch_write |=> $stable(s_q.latch))
    else $error("latch changed by a push or pop");

  a_push_wraps: assert property (
    s_push_alone |=> s_q.sp == 3'($past(s_q.sp) + 3'h1))
    else $error("stack pointer did not advance modulo eight");

  a_pop_retreats: assert property (
    s_return_alone |=> s_q.sp == 3'($past(s_q.sp) - 3'h1))
    else $error("stack pointer did not retreat modulo eight");

  a_bus_no_stack: assert property (
    bus_req && !return_op_i && !subroutine_op_i && !interrupt_vector_i |=> $stable(s_q.sp))
    else $error("bus access moved the stack pointer");

  a_low_read_data: assert property (
    bus_req && !we_i && adr_i == pc_stack_pkg::OFFSET_PC_LOW |=>
      ack_o && dat_o == {24'h000000, $past(pc_o[7:0])})
    else $error("low byte read returned wrong data");

  a_advance_step: assert property (
    ev == pc_stack_pkg::EV_ADVANCE |=> pc_o == 13'($past(pc_o) + 13'h0001))
    else $error("pc did not advance by one");

  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  // ==========================================================================
  // event and bus access sequences
  sequence s_vector_taken;
    ev == pc_stack_pkg::EV_VECTOR;
  endsequence

  sequence s_call_taken;
    ev == pc_stack_pkg::EV_CALL;
  endsequence

  sequence s_pop_taken;
    ev == pc_stack_pkg::EV_RETURN;
  endsequence

  sequence s_latch_read;
    bus_req && !we_i && adr_i == pc_stack_pkg::OFFSET_PC_LATCH;
  endsequence

  sequence s_unmapped_access;
    bus_req && adr_i != pc_stack_pkg::OFFSET_PC_LOW && adr_i != pc_stack_pkg::OFFSET_PC_LATCH;
  endsequence

  // ==========================================================================
  // vector and stack checks
  a_vector_target: assert property (
    s_vector_taken |=> pc_o == VECTOR_ADDR)
    else $error("vector did not load the vector address");

  a_vector_push: assert property (
    s_vector_taken |=> s_q.stack[$past(s_q.sp)] == $past(pc_o))
    else $error("vector did not push the pc");

  a_call_push: assert property (
    s_call_taken |=> s_q.stack[$past(s_q.sp)] == $past(pc_o))
    else $error("call did not push the pc");

  a_return_restore: assert property (
    s_pop_taken |=> pc_o == $past(s_q.stack[pop_index]))
    else $error("return did not restore the popped entry");

  a_pop_keeps_stack: assert property (
    s_pop_taken |=> $stable(s_q.stack))
    else $error("pop changed a stack entry");

  a_quiet_keeps_stack: assert property (
    !push_en && !pop_en |=> $stable(s_q.sp) && $stable(s_q.stack))
    else $error("stack moved without a call, vector or return");

  a_push_wrap_edge: assert property (
    push_en && s_q.sp == pc_stack_pkg::STACK_DEPTH - 1 |=>
      s_q.sp == pc_stack_pkg::SP_RESET)
    else $error("pointer did not wrap after eighth entry");

  a_pop_wrap_edge: assert property (
    pop_en && s_q.sp == pc_stack_pkg::SP_RESET |=>
      s_q.sp == pc_stack_pkg::STACK_DEPTH - 1)
    else $error("pointer did not wrap below first entry");

  a_reset_stack_clear: assert property (
    $past(rst_i) |-> s_q.stack == '0)
    else $error("stack not cleared by reset");

  // ==========================================================================
  // bus checks
  a_latch_read_data: assert property (
    s_latch_read |=> ack_o && dat_o[pc_stack_pkg::LATCH_WIDTH-1:0] == $past(s_q.latch) &&
      dat_o[pc_stack_pkg::DATA_WIDTH-1:pc_stack_pkg::LATCH_WIDTH] == '0)
    else $error("latch read returned wrong data");

  a_unmapped_read_zero: assert property (
    s_unmapped_access ##0 !we_i |=> ack_o && dat_o == '0)
    else $error("unmapped read returned data");

  a_unmapped_write_kept: assert property (
    s_unmapped_access ##0 we_i |=> $stable(s_q.latch))
    else $error("unmapped write changed the latch");

  a_latch_write_load: assert property (
    latch_write |=> s_q.latch == $past(dat_i[pc_stack_pkg::LATCH_WIDTH-1:0]))
    else $error("latch write not stored");

  a_ack_follows_req: assert property (
    bus_req |=> ack_o)
    else $error("request not acknowledged in the next cycle");

  a_idle_no_ack: assert property (
    !bus_req |=> !ack_o)
    else $error("ack without a request");

  // ==========================================================================
  // pc checks
  a_pc_holds_idle: assert property (
    ev == pc_stack_pkg::EV_NONE |=> $stable(pc_o))
    else $error("pc changed without an event");

endmodule

// File: pc_stack_pkg.sv
package pc_stack_pkg;

  // ==========================================================================
  // widths
  localparam int PC_WIDTH      = 13;
  localparam int LOW_WIDTH     = 8;
  localparam int LATCH_WIDTH   = 5;
  localparam int BRANCH_WIDTH  = 11;
  localparam int STACK_DEPTH   = 8;
  localparam int SP_WIDTH      = 3;
  localparam int ADR_WIDTH     = 4;
  localparam int DATA_WIDTH    = 32;

  // ==========================================================================
  // field positions of the high latch
  localparam int PAGE_HI_BIT   = 4;
  localparam int PAGE_LO_BIT   = 3;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [ADR_WIDTH-1:0] OFFSET_PC_LOW   = 4'h0;
  localparam logic [ADR_WIDTH-1:0] OFFSET_PC_LATCH = 4'h4;

  // ==========================================================================
  // reset values and step sizes
  localparam logic [PC_WIDTH-1:0]    PC_RESET    = 13'h0000;
  localparam logic [LATCH_WIDTH-1:0] LATCH_RESET = 5'h00;
  localparam logic [SP_WIDTH-1:0]    SP_RESET    = 3'h0;
  localparam logic [PC_WIDTH-1:0]    PC_STEP     = 13'h0001;
  localparam logic [SP_WIDTH-1:0]    SP_STEP     = 3'h1;

  // ==========================================================================
  // kinds of core event: EV_NONE (lowest), then the rest highest priority first
  typedef enum logic [2:0] {
    EV_NONE,
    EV_VECTOR,
    EV_RETURN,
    EV_CALL,
    EV_JUMP,
    EV_LOW_WRITE,
    EV_ADVANCE
  } event_type;

endpackage

// File: core_model.sv
module core_model (
  output logic        advance_o,
  output logic        jump_o,
  output logic        call_o,
  output logic        return_o,
  output logic        vector_o,
  output logic [10:0] addr_o,
  input  wire logic   clk_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // decoder side: one event per call, held for one edge
  initial {advance_o, jump_o, call_o, return_o, vector_o, addr_o} = '0;
  // k: 0 vector, 1 return, 2 call, 3 jump, 4 advance
  task automatic fire(input int k, input logic [10:0] a);
    @(posedge clk_i);
    {advance_o, jump_o, call_o, return_o, vector_o} <= 5'h01 << k;
    addr_o <= a;
    @(posedge clk_i);
    {advance_o, jump_o, call_o, return_o, vector_o} <= 5'h00;
  endtask
  // call followed at once by a return that must undo it
  task automatic call_then_return(input logic [10:0] a);
    @(posedge clk_i);
    call_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    call_o   <= 1'b0;
    return_o <= 1'b1;
    @(posedge clk_i);
    return_o <= 1'b0;
  endtask
endmodule

// File: tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [12:0] VEC = 13'h0004;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, adv, jmp, cal, ret, vec, ack_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [10:0] ba;
  logic [12:0] pc_o, exp_pc;
  logic [12:0] stk [8];
  logic [2:0]  sp;
  logic [4:0]  latch;
  int failures, tests_run;
  program_counter_and_return_stack #(.VECTOR_ADDR(VEC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .advance_i(adv), .direct_jump_op_i(jmp), .subroutine_op_i(cal),
    .branch_addr_i(ba), .return_op_i(ret), .interrupt_vector_i(vec), .pc_o(pc_o));
  core_model core (.advance_o(adv), .jump_o(jmp), .call_o(cal), .return_o(ret),
    .vector_o(vec), .addr_o(ba), .clk_i(clk_i));
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  // ==========================================================================
  // reporting
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // bus and core tasks
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
    for (n = 0; n < 50 && ack_o !== 1'b1; n++) @(posedge clk_i);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    if (n < 50) begin
      if (w && a == 4'h4) latch = d[4:0];
      if (w && a == 4'h0) exp_pc = {latch, d};
    end else begin
      failures++;
      end_sim();
    end
  endtask
  task automatic ev(input int k, input logic [10:0] a);
    core.fire(k, a);
    if (k == 0 || k == 2) begin
      stk[sp] = exp_pc;
      sp++;
    end
    case (k)
      0: exp_pc = VEC;
      1: begin
        sp--;
        exp_pc = stk[sp];
      end
      4: exp_pc = exp_pc + 13'h0001;
      default: exp_pc = {latch[4:3], a};
    endcase
    @(negedge clk_i);
    chk({19'h0, pc_o}, {19'h0, exp_pc});
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    {exp_pc, sp, latch} = '0;
    @(negedge clk_i);
    chk({19'h0, pc_o}, 32'h0);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_registers();
    wb(1'b1, 4'h4, 8'hff);
    wb(1'b1, 4'h0, 8'h5a);
    @(negedge clk_i);
    chk({19'h0, pc_o}, 32'h1f5a);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h5a);
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'h1f);
    wb(1'b1, 4'h8, 8'h00);
    wb(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'h1f);
  endtask
  task automatic t_stack();
    ev(3, 11'h123);
    for (int i = 0; i < 10; i++) ev(2, 11'(i * 16 + 1));
    ev(4, 11'h0);
    for (int i = 0; i < 10; i++) ev(1, 11'h0);
    ev(0, 11'h0);
    ev(1, 11'h0);
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'h1f);
  endtask
  task automatic t_call_return();
    stk[sp] = exp_pc;
    core.call_then_return(11'h2aa);
    @(negedge clk_i);
    chk({19'h0, pc_o}, {19'h0, exp_pc});
  endtask
  // software table jump: carry out of the low byte bumps the latch
  task automatic t_computed_jump();
    logic [8:0] sum;
    wb(1'b1, 4'h0, 8'h80);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h80);
    sum = {1'b0, rd[7:0]} + 9'h090;
    if (sum[8]) wb(1'b1, 4'h4, {3'h0, latch + 5'h01});
    wb(1'b1, 4'h0, sum[7:0]);
    @(negedge clk_i);
    chk({19'h0, pc_o}, {19'h0, latch, sum[7:0]});
  endtask
  task automatic t_reset_again();
    do_reset();
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'h0);
  endtask
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    failures = 0;
    tests_run = 0;
    do_reset();
    t_registers();
    t_stack();
    t_call_return();
    t_computed_jump();
    t_reset_again();
    end_sim();
  end
endmodule
